// *** hw/isr_pkg.sv ***
// Constants, types and helpers of the instrument status reporting block
// Assumes a single system clock; all codes below are shared by the hw files and the bench top
//
// Overview of operation
// - Clear-status empties events and error queue; status byte stays live
// - Enabled events OR together into event summary
// - Reading event flags returns them, then clears
// - Event mask shares event flag bit positions
// - Event bits: complete, query, device, exec, command, power
// - Complete-op clears bit zero; sets when idle
// - Reset command restores defaults; others unchanged
// - Masked status byte bits OR into bit six
// - Zero request mask never raises service request
// - Status byte: questionable, message, event, request
// - Status byte follows sources; reading never clears
// - Self-test returns zero on pass, one on fail
// - Wait holds later commands until earlier finish
// - Condition word live, read-only, reset-immune
// - Condition bits zero to six flag faults
// - Condition bits seven to ten show regulation
// - Bit eleven ORs soft, twelve ORs hard
// - Bits thirteen to fifteen: interlock, power, input
// - Indexed live status words, read-only, never cleared
// - Unindexed status query returns two words
// - Error FIFO; empty reads zero; overflow marks last
package isr_pkg;

    // Widths
    localparam int EV_W   = 8;
    localparam int STB_W  = 8;
    localparam int QUES_W = 16;
    localparam int WORD_W = 32;
    localparam int ERR_W  = 16;

    // Defaults of module parameters
    localparam int ERR_DEPTH_DEF  = 16;
    localparam int STAT_WORDS_DEF = 2;

    // Event flag bit positions, shared with the event mask
    localparam int EV_OPC = 0;
    localparam int EV_QRY = 2;
    localparam int EV_DEV = 3;
    localparam int EV_EXC = 4;
    localparam int EV_CMD = 5;
    localparam int EV_PWR = 7;
    localparam logic [EV_W-1:0] EV_RESET = 8'h80; // Power-on flag set

    // Status byte bit positions
    localparam int SB_QUES = 3;
    localparam int SB_MAV  = 4;
    localparam int SB_ESB  = 5;
    localparam int SB_RQS  = 6;
    localparam logic [STB_W-1:0] SRM_WR_MASK = 8'hBF; // Request bit excluded

    // Condition word: fault classes over the low eleven bits
    localparam logic [10:0] Q_SOFT_MASK = 11'h00E;
    localparam logic [10:0] Q_HARD_MASK = 11'h071;

    // Error codes and event class ranges
    localparam logic signed [ERR_W-1:0] ERR_NONE     = 16'sh0000;
    localparam logic signed [ERR_W-1:0] ERR_OVERFLOW = -16'sd350;
    localparam logic signed [ERR_W-1:0] ERR_CMD_HI   = -16'sd100;
    localparam logic signed [ERR_W-1:0] ERR_CMD_LO   = -16'sd199;
    localparam logic signed [ERR_W-1:0] ERR_EXC_HI   = -16'sd200;
    localparam logic signed [ERR_W-1:0] ERR_EXC_LO   = -16'sd299;
    localparam logic signed [ERR_W-1:0] ERR_DEV_HI   = -16'sd300;
    localparam logic signed [ERR_W-1:0] ERR_DEV_LO   = -16'sd399;
    localparam logic signed [ERR_W-1:0] ERR_QRY_HI   = -16'sd400;
    localparam logic signed [ERR_W-1:0] ERR_QRY_LO   = -16'sd499;

    // Self-test and operation-complete answers
    localparam logic [WORD_W-1:0] TST_PASS = 32'h0000_0000;
    localparam logic [WORD_W-1:0] TST_FAIL = 32'h0000_0001;
    localparam logic [WORD_W-1:0] OPC_DONE = 32'h0000_0001;

    // Commands and queries of the command port
    typedef enum logic [4:0] {
        CMD_CLS      = 5'b00000,
        CMD_ESE_WR   = 5'b00001,
        CMD_ESE_RD   = 5'b00010,
        CMD_EVF_RD   = 5'b00011,
        CMD_OPC      = 5'b00100,
        CMD_OPC_RD   = 5'b00101,
        CMD_RST      = 5'b00110,
        CMD_SRM_WR   = 5'b00111,
        CMD_SRM_RD   = 5'b01000,
        CMD_STB_RD   = 5'b01001,
        CMD_TST      = 5'b01010,
        CMD_WAI      = 5'b01011,
        CMD_QUES_RD  = 5'b01100,
        CMD_WORD_RD  = 5'b01101,
        CMD_WORDS_RD = 5'b01110,
        CMD_ERR_RD   = 5'b01111,
        CMD_ERR_CNT  = 5'b10000
    } isr_cmd_t;

    // Event class of a queued error code
    function automatic logic [EV_W-1:0] isr_event_of(
        input logic signed [ERR_W-1:0] code
    );
        logic [EV_W-1:0] ev;
        ev = 8'h00;
        ev[EV_CMD] = (code <= ERR_CMD_HI) && (code >= ERR_CMD_LO);
        ev[EV_EXC] = (code <= ERR_EXC_HI) && (code >= ERR_EXC_LO);
        ev[EV_DEV] = (code <= ERR_DEV_HI) && (code >= ERR_DEV_LO);
        ev[EV_QRY] = (code <= ERR_QRY_HI) && (code >= ERR_QRY_LO);
        return ev;
    endfunction

endpackage

// *** hw/isr_err_if.sv ***
// Carrier between the status top and its error queue
// Assumes one producer (top) and one queue on the same clock
interface isr_err_if
    import isr_pkg::*;
#(
    parameter int DEPTH = ERR_DEPTH_DEF
);
    logic                    push;
    logic [ERR_W-1:0]        code;
    logic                    pop;
    logic                    clear;
    logic [ERR_W-1:0]        rd_code;
    logic [$clog2(DEPTH):0]  count;

    modport queue (input push, code, pop, clear, output rd_code, count);
    modport user  (output push, code, pop, clear, input rd_code, count);
endinterface

// *** hw/isr_err_queue.sv ***
// First-in first-out error queue with registered read data
// Assumes pop and clear never come in the same cycle
module isr_err_queue
    import isr_pkg::*;
#(
    parameter int DEPTH = ERR_DEPTH_DEF
) (
    // Clock and synchronised reset
    input  wire logic sys_clk_in,
    input  wire logic rst_n_in,
    // Queue side of the carrier
    isr_err_if.queue  q
);
    localparam int PW = $clog2(DEPTH);

    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
        $error("isr_err_queue: DEPTH must be a power of two");
    end

    typedef struct packed {
        logic [DEPTH-1:0][ERR_W-1:0] mem;
        logic [PW-1:0]               wp;
        logic [PW-1:0]               rp;
        logic [PW:0]                 cnt;
        logic [ERR_W-1:0]            rd;
    } isr_q_state_t;

    isr_q_state_t s_q;
    isr_q_state_t s_d;

    // Pop, then clear, then push: a push survives a clear; when full it marks the last entry as overflow
    always_comb begin
        s_d = s_q;
        if (q.pop) begin
            s_d.rd = (s_q.cnt == '0) ? ERR_NONE : s_q.mem[s_q.rp];
            if (s_q.cnt != '0) begin
                s_d.rp  = s_q.rp + 1'b1;
                s_d.cnt = s_q.cnt - 1'b1;
            end
        end
        if (q.clear) begin
            s_d.wp  = '0;
            s_d.rp  = '0;
            s_d.cnt = '0;
        end
        if (q.push) begin
            if (s_d.cnt == DEPTH) begin
                s_d.mem[s_d.wp - 1'b1] = ERR_OVERFLOW;
            end else begin
                s_d.mem[s_d.wp] = q.code;
                s_d.wp          = s_d.wp + 1'b1;
                s_d.cnt         = s_d.cnt + 1'b1;
            end
        end
    end

    // State register
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs
    assign q.rd_code = s_q.rd;
    assign q.count   = s_q.cnt;
endmodule

// *** hw/isr_status_top.sv ***
// Status reporting top: event flags, masks, status byte, live words
// Assumes one command at a time, held until cmd_ready_out is high
module isr_status_top
    import isr_pkg::*;
#(
    parameter int ERR_DEPTH = ERR_DEPTH_DEF,
    parameter int NUM_WORDS = STAT_WORDS_DEF
) (
    // Clock and reset
    input  wire logic                        sys_clk_in,
    input  wire logic                        reset_n_in,
    // Command port
    input  wire logic                        cmd_valid_in,
    input  wire isr_cmd_t                    cmd_code_in,
    input  wire logic [WORD_W-1:0]           cmd_arg_in,
    output logic                             cmd_ready_out,
    // Response port
    output logic                             rsp_valid_out,
    output logic [WORD_W-1:0]                rsp_data_out,
    // Device activity and errors
    input  wire logic                        exec_busy_in,
    input  wire logic                        msg_avail_in,
    input  wire logic                        err_push_in,
    input  wire logic [ERR_W-1:0]            err_code_in,
    // Self-test handshake
    output logic                             selftest_start_out,
    input  wire logic                        selftest_done_in,
    input  wire logic                        selftest_fail_in,
    // Live fault conditions
    input  wire logic                        overvolt_protect_fault_in,
    input  wire logic                        overcurrent_trip_fault_in,
    input  wire logic                        overvolt_trip_fault_in,
    input  wire logic                        overpower_trip_fault_in,
    input  wire logic                        overcurrent_protect_fault_in,
    input  wire logic                        overtemp_protect_fault_in,
    input  wire logic                        sense_loss_fault_in,
    // Live regulation mode
    input  wire logic                        const_current_active_in,
    input  wire logic                        const_voltage_active_in,
    input  wire logic                        const_resistance_active_in,
    input  wire logic                        const_power_active_in,
    // Live system flags
    input  wire logic                        interlock_open_flag_in,
    input  wire logic                        input_power_loss_flag_in,
    input  wire logic                        user_input_fault_flag_in,
    // Wide live status words, word 0 in the low bits
    input  wire logic [NUM_WORDS*WORD_W-1:0] status_words_in,
    // Status outputs
    output logic                             service_request_out,
    output logic                             settings_reset_out
);

    if (NUM_WORDS < 2 || NUM_WORDS > 256) begin : g_chk
        $error("isr_status_top: NUM_WORDS must be 2 to 256");
    end

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_WAIT  = 3'b001,
        ST_ERR   = 3'b010,
        ST_TEST  = 3'b011,
        ST_WORD1 = 3'b100
    } isr_state_t;

    typedef struct packed {
        isr_state_t        st;
        logic [EV_W-1:0]   evf;
        logic [EV_W-1:0]   ese;
        logic [STB_W-1:0]  srm;
        logic              opc_pend;
        logic              opc_query;
        logic              rsp_v;
        logic [WORD_W-1:0] rsp;
        logic              srq;
        logic              rst_pulse;
        logic              st_go;
    } isr_top_state_t;

    localparam isr_top_state_t TOP_RESET = '{
        st: ST_IDLE, evf: EV_RESET, ese: '0, srm: '0, opc_pend: 1'b0,
        opc_query: 1'b0, rsp_v: 1'b0, rsp: '0, srq: 1'b0,
        rst_pulse: 1'b0, st_go: 1'b0
    };

    isr_top_state_t s_q;
    isr_top_state_t s_d;
    logic [1:0]     rst_sync_q;
    logic           rst_n;

    // Reset release through two flip-flops
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rst_sync_q <= 2'b00;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // Error queue
    isr_err_if #(.DEPTH(ERR_DEPTH)) err_bus ();

    isr_err_queue #(.DEPTH(ERR_DEPTH)) u_queue (
        .sys_clk_in (sys_clk_in),
        .rst_n_in   (rst_n),
        .q          (err_bus)
    );

    // Live condition word, never stored
    logic [10:0]       ques_low;
    logic              soft_sum;
    logic              hard_sum;
    logic [QUES_W-1:0] ques;

    assign ques_low = {const_power_active_in, const_resistance_active_in,
                       const_voltage_active_in, const_current_active_in,
                       sense_loss_fault_in, overtemp_protect_fault_in,
                       overcurrent_protect_fault_in, overpower_trip_fault_in,
                       overvolt_trip_fault_in, overcurrent_trip_fault_in,
                       overvolt_protect_fault_in};
    assign soft_sum = |(ques_low & Q_SOFT_MASK);
    assign hard_sum = |(ques_low & Q_HARD_MASK);
    assign ques = {user_input_fault_flag_in, input_power_loss_flag_in,
                   interlock_open_flag_in, hard_sum, soft_sum,
                   ques_low};

    // Status byte built from its sources only
    logic             esb;
    logic             rqs;
    logic [STB_W-1:0] stb_src;
    logic [STB_W-1:0] stb;

    assign esb     = |(s_q.evf & s_q.ese);
    assign stb_src = {2'b00, esb, msg_avail_in, |ques, 3'b000};
    assign rqs     = |(stb_src & s_q.srm);
    assign stb     = {1'b0, rqs, stb_src[5:0]};

    // Handshake and event sources
    logic            take;
    logic            opc_fire;
    logic [EV_W-1:0] ev_set;

    assign cmd_ready_out = (s_q.st == ST_IDLE);
    assign take          = cmd_valid_in && cmd_ready_out;
    assign opc_fire      = s_q.opc_pend && !exec_busy_in;
    assign ev_set = (err_push_in ? isr_event_of(err_code_in) : 8'h00)
                  | {7'b0000000, opc_fire};

    // Queue controls
    assign err_bus.push  = err_push_in;
    assign err_bus.code  = err_code_in;
    assign err_bus.pop   = take && (cmd_code_in == CMD_ERR_RD);
    assign err_bus.clear = take && (cmd_code_in == CMD_CLS);

    // Next state: commands, then events so that a set wins
    always_comb begin
        s_d           = s_q;
        s_d.rsp_v     = 1'b0;
        s_d.rst_pulse = 1'b0;
        s_d.st_go     = 1'b0;
        s_d.srq       = rqs;
        if (opc_fire) begin
            s_d.opc_pend = 1'b0;
        end
        unique case (s_q.st)
            ST_IDLE: begin
                if (take) begin
                    unique case (cmd_code_in)
                        CMD_CLS: begin
                            s_d.evf = '0;
                        end
                        CMD_ESE_WR: begin
                            s_d.ese = cmd_arg_in[EV_W-1:0];
                        end
                        CMD_ESE_RD: begin
                            s_d.rsp_v = 1'b1;
                            s_d.rsp   = {24'h000000, s_q.ese};
                        end
                        CMD_EVF_RD: begin
                            s_d.rsp_v = 1'b1;
                            s_d.rsp   = {24'h000000, s_q.evf};
                            s_d.evf   = '0;
                        end
                        CMD_OPC: begin
                            s_d.evf[EV_OPC] = 1'b0;
                            s_d.opc_pend    = 1'b1;
                        end
                        CMD_OPC_RD: begin
                            s_d.st        = ST_WAIT;
                            s_d.opc_query = 1'b1;
                        end
                        CMD_RST: begin
                            s_d.rst_pulse = 1'b1;
                        end
                        CMD_SRM_WR: begin
                            s_d.srm = cmd_arg_in[STB_W-1:0] & SRM_WR_MASK;
                        end
                        CMD_SRM_RD: begin
                            s_d.rsp_v = 1'b1;
                            s_d.rsp   = {24'h000000, s_q.srm};
                        end
                        CMD_STB_RD: begin
                            s_d.rsp_v = 1'b1;
                            s_d.rsp   = {24'h000000, stb};
                        end
                        CMD_TST: begin
                            s_d.st    = ST_TEST;
                            s_d.st_go = 1'b1;
                        end
                        CMD_WAI: begin
                            s_d.st        = ST_WAIT;
                            s_d.opc_query = 1'b0;
                        end
                        CMD_QUES_RD: begin
                            s_d.rsp_v = 1'b1;
                            s_d.rsp   = {16'h0000, ques};
                        end
                        CMD_WORD_RD: begin
                            s_d.rsp_v = 1'b1;
                            s_d.rsp   = '0;
                            if (cmd_arg_in < NUM_WORDS) begin
                                s_d.rsp = status_words_in[
                                    WORD_W*int'(cmd_arg_in[7:0]) +: WORD_W
                                ];
                            end
                        end
                        CMD_WORDS_RD: begin
                            s_d.rsp_v = 1'b1;
                            s_d.rsp   = status_words_in[WORD_W-1:0];
                            s_d.st    = ST_WORD1;
                        end
                        CMD_ERR_RD: begin
                            s_d.st = ST_ERR;
                        end
                        CMD_ERR_CNT: begin
                            s_d.rsp_v = 1'b1;
                            s_d.rsp   = WORD_W'(err_bus.count);
                        end
                        default: begin
                            s_d.rsp_v = 1'b0;
                        end
                    endcase
                end
            end
            ST_WAIT: begin
                if (!exec_busy_in) begin
                    s_d.st    = ST_IDLE;
                    s_d.rsp_v = s_q.opc_query;
                    s_d.rsp   = s_q.opc_query ? OPC_DONE : s_q.rsp;
                end
            end
            ST_ERR: begin
                s_d.st    = ST_IDLE;
                s_d.rsp_v = 1'b1;
                s_d.rsp   = WORD_W'(signed'(err_bus.rd_code));
            end
            ST_TEST: begin
                if (selftest_done_in) begin
                    s_d.st    = ST_IDLE;
                    s_d.rsp_v = 1'b1;
                    s_d.rsp   = selftest_fail_in ? TST_FAIL : TST_PASS;
                end
            end
            ST_WORD1: begin
                s_d.st    = ST_IDLE;
                s_d.rsp_v = 1'b1;
                s_d.rsp   = status_words_in[2*WORD_W-1:WORD_W];
            end
            default: begin
                s_d.st = ST_IDLE;
            end
        endcase
        s_d.evf = s_d.evf | ev_set;
    end

    // State register
    always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= TOP_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs
    assign rsp_valid_out       = s_q.rsp_v;
    assign rsp_data_out        = s_q.rsp;
    assign service_request_out = s_q.srq;
    assign settings_reset_out  = s_q.rst_pulse;
    assign selftest_start_out  = s_q.st_go;

    // Checks on the block's own behaviour
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!rst_n);

    logic quiet;
    assign quiet = !err_push_in && !opc_fire;

    chk_cls_clear: assert property (
        take && cmd_code_in == CMD_CLS && quiet
        |=> s_q.evf == 8'h00 && err_bus.count == '0
    ) else $error("clear-status left flags or errors");

    chk_esb_summary: assert property (
        take && cmd_code_in == CMD_STB_RD
        |=> rsp_valid_out
            && rsp_data_out[SB_ESB] == |($past(s_q.evf) & $past(s_q.ese))
    ) else $error("event summary not the OR of enabled events");

    chk_evf_rdclr: assert property (
        take && cmd_code_in == CMD_EVF_RD && quiet
        |=> rsp_valid_out && rsp_data_out[7:0] == $past(s_q.evf)
            && s_q.evf == 8'h00
    ) else $error("event flag read did not return and clear");

    chk_opc_clear: assert property (
        take && cmd_code_in == CMD_OPC && exec_busy_in && !err_push_in
        |=> !s_q.evf[EV_OPC] && s_q.opc_pend
    ) else $error("operation complete not cleared");

    chk_opc_set: assert property (
        s_q.opc_pend && !exec_busy_in |=> s_q.evf[EV_OPC] && !s_q.opc_pend
    ) else $error("operation complete not set when idle");

    chk_rqs_zero: assert property (
        s_q.srm == 8'h00 ##1 s_q.srm == 8'h00 |-> !service_request_out
    ) else $error("service request with zero mask");

    chk_rqs_or: assert property (
        ##1 service_request_out == |($past(stb_src) & $past(s_q.srm))
    ) else $error("request bit not OR of masked status bits");

    chk_stb_keep: assert property (
        take && cmd_code_in == CMD_STB_RD && quiet && !msg_avail_in
        ##1 !msg_avail_in && $stable(ques)
        |-> stb_src == $past(stb_src)
    ) else $error("status byte changed by a read");

    chk_fault_sums: assert property (
        take && cmd_code_in == CMD_QUES_RD
        |=> rsp_data_out[11] == |($past(ques_low[3:1]))
            && rsp_data_out[12] == |{$past(ques_low[6:4]),
                                     $past(ques_low[0])}
    ) else $error("fault summary bits wrong");

    chk_wai_hold: assert property (
        take && cmd_code_in == CMD_WAI ##1 exec_busy_in [*2]
        |-> !cmd_ready_out && $past(!cmd_ready_out)
    ) else $error("command taken while waiting");

    chk_tst_answer: assert property (
        s_q.st == ST_TEST && selftest_done_in
        |=> rsp_valid_out
            && rsp_data_out == ($past(selftest_fail_in) ? 32'h1 : 32'h0)
    ) else $error("self-test answer wrong");

    chk_err_empty: assert property (
        take && cmd_code_in == CMD_ERR_RD && err_bus.count == '0
        && !err_push_in
        |-> ##2 rsp_valid_out && rsp_data_out == 32'h0
    ) else $error("empty error queue did not read zero");

    chk_two_words: assert property (
        take && cmd_code_in == CMD_WORDS_RD
        |=> rsp_valid_out ##1 rsp_valid_out ##1 !rsp_valid_out
    ) else $error("status query did not give two words");

endmodule

// *** dv/isr_dev_model.sv ***
// Device activity model: execution busy span and a slow self-test engine
// Assumes the bench kicks busy spans and picks the self-test verdict
module isr_dev_model (
    // Clock and controls
    input  wire logic clk_in,
    input  wire logic kick_in,
    input  wire logic start_in,
    input  wire logic fail_in,
    // Activity outputs
    output logic      busy_out,
    output logic      done_out,
    output logic      fail_out
);
    timeunit 1ns;
    timeprecision 1ps;
    int bc = 0;
    int tc = 0;
    // Busy lasts ten cycles; test answers three cycles after start
    always @(posedge clk_in) begin
        bc <= kick_in ? 10 : (bc > 0 ? bc - 1 : 0);
        tc <= start_in ? 4 : (tc > 0 ? tc - 1 : 0);
    end
    assign busy_out = bc != 0;
    assign done_out = tc == 1;
    assign fail_out = fail_in;
endmodule

// *** dv/instrument_status_reporting_tb_top.sv ***
// Bench of the status block: command driver, reference model, checks
// Assumes the design under hw/ and the activity model beside this file
module instrument_status_reporting_tb_top import isr_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 0, rst_n = 0, vld = 0, push = 0, msg = 0, kick = 0;
    logic        tfail = 0, rdy, rv, srq, srst, tst, busy, done, fl;
    isr_cmd_t    code = CMD_CLS;
    logic [31:0] arg = 0, d, rdat, s = 32'hFF4E;
    logic [15:0] f = 0, ec = 0;
    logic [63:0] w = 0;
    logic [7:0]  ev = 8'h80, ese = 0, srm = 0;
    int          n_errors = 0, compares = 0, cyc = 0, np = 0, eq[$];
    int          cl[5] = '{-102, -222, -310, -400, -108};
    logic [31:0] rq[$];
    isr_status_top #(.ERR_DEPTH(4), .NUM_WORDS(2)) i_isr_status_top (
        .sys_clk_in(clk), .reset_n_in(rst_n), .cmd_valid_in(vld),
        .cmd_code_in(code), .cmd_arg_in(arg), .cmd_ready_out(rdy),
        .rsp_valid_out(rv), .rsp_data_out(rdat), .exec_busy_in(busy),
        .msg_avail_in(msg), .err_push_in(push), .err_code_in(ec),
        .selftest_start_out(tst), .selftest_done_in(done),
        .selftest_fail_in(fl), .overvolt_protect_fault_in(f[0]),
        .overcurrent_trip_fault_in(f[1]), .overvolt_trip_fault_in(f[2]),
        .overpower_trip_fault_in(f[3]),
        .overcurrent_protect_fault_in(f[4]),
        .overtemp_protect_fault_in(f[5]), .sense_loss_fault_in(f[6]),
        .const_current_active_in(f[7]), .const_voltage_active_in(f[8]),
        .const_resistance_active_in(f[9]), .const_power_active_in(f[10]),
        .interlock_open_flag_in(f[13]), .input_power_loss_flag_in(f[14]),
        .user_input_fault_flag_in(f[15]), .status_words_in(w),
        .service_request_out(srq), .settings_reset_out(srst));
    isr_dev_model i_isr_dev_model (.clk_in(clk), .kick_in(kick),
        .start_in(tst), .fail_in(tfail), .busy_out(busy), .done_out(done),
        .fail_out(fl));
    initial forever #5 clk = ~clk;
    // Answer capture and reset pulse count, away from the rising edge
    always @(negedge clk) begin
        if (rv === 1'b1) rq.push_back(rdat);
        if (srst === 1'b1) np++;
    end
    // Hang guard
    always @(posedge clk) if (++cyc == 20000) begin
        n_errors++;
        finish_test();
    end
    function automatic logic [31:0] rnd();
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    // Reference condition word and status byte
    function automatic logic [15:0] qw();
        return {f[15:13], |(f[6:0] & 7'h71), |(f[6:0] & 7'h0E), f[10:0]};
    endfunction
    function automatic logic [7:0] stb();
        logic [7:0] b;
        b = {2'b00, |(ev & ese), msg, |qw(), 3'b000};
        return {b[7], |(b & srm & 8'hBF), b[5:0]};
    endfunction
    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        compares++;
        if (g !== e) begin
            n_errors++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask
    // Command held until the edge where ready is high
    task automatic cmd(isr_cmd_t c, logic [31:0] a = 0);
        @(posedge clk) begin vld <= 1; code <= c; arg <= a; end
        do @(negedge clk); while (rdy !== 1'b1);
        @(posedge clk) vld <= 0;
    endtask
    task automatic get(output logic [31:0] v);
        repeat (40) if (rq.size() == 0) @(negedge clk);
        v = rq.size() ? rq.pop_front() : 32'hDEAD_BEEF;
    endtask
    task automatic rd(isr_cmd_t c, logic [31:0] a, string n, logic [31:0] e);
        cmd(c, a);
        get(d);
        chk(n, e, d);
    endtask
    task automatic perr(int c);
        @(posedge clk) begin push <= 1; ec <= c[15:0]; end
        @(posedge clk) push <= 0;
        for (int b = 1; b < 5; b++) if (c <= -100*b && c > -100*b-100) ev[6-b] = 1;
        if (eq.size() == 4) eq[3] = -350; else eq.push_back(c);
    endtask
    task automatic finish_test();
        $display("compares %0d errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1;
        repeat (3) @(posedge clk);
        rd(CMD_EVF_RD, 0, "evf", 8'h80);
        ev = 0;
        rd(CMD_EVF_RD, 0, "evf", 0);
        foreach (cl[i]) perr(cl[i]);
        rd(CMD_ERR_CNT, 0, "cnt", 4);
        repeat (5) rd(CMD_ERR_RD, 0, "err", eq.size() ? eq.pop_front() : 0);
        $display("error queue test done");
        for (int i = 0; i < 4; i++) begin
            @(posedge clk) begin
                f <= 16'(rnd());
                w <= {rnd(), rnd()};
                msg <= s[3];
            end
            ese = 8'(rnd());
            srm = i ? 8'(rnd()) & 8'hBF : 8'h00;
            perr(cl[i]);
            cmd(CMD_ESE_WR, ese);
            cmd(CMD_SRM_WR, srm | 8'h40);
            rd(CMD_ESE_RD, 0, "ese", ese);
            rd(CMD_SRM_RD, 0, "srm", srm);
            rd(CMD_STB_RD, 0, "stb", stb());
            rd(CMD_STB_RD, 0, "stb", stb());
            chk("srq", 32'((stb() & 8'h40) != 0), 32'(srq));
            rd(CMD_QUES_RD, 0, "ques", qw());
            rd(CMD_WORD_RD, i & 1, "word", i & 1 ? w[63:32] : w[31:0]);
            cmd(CMD_WORDS_RD);
            get(d);
            chk("w0", w[31:0], d);
            get(d);
            chk("w1", w[63:32], d);
            rd(CMD_EVF_RD, 0, "evf", ev);
            ev = 0;
        end
        rd(CMD_WORD_RD, 2, "word", 0);
        $display("mask and status test done");
        @(posedge clk) kick <= 1;
        @(posedge clk) kick <= 0;
        cmd(CMD_OPC);
        cmd(CMD_WAI);
        @(negedge clk) chk("wai", 0, 32'(rdy));
        rd(CMD_OPC_RD, 0, "opc", 1);
        rd(CMD_EVF_RD, 0, "evf", 1);
        for (int i = 0; i < 2; i++) begin
            @(posedge clk) tfail <= i[0];
            rd(CMD_TST, 0, "tst", i);
        end
        $display("sync and self test done");
        cmd(CMD_RST);
        repeat (3) @(negedge clk);
        chk("rstp", 1, np);
        rd(CMD_ESE_RD, 0, "ese", ese);
        rd(CMD_QUES_RD, 0, "ques", qw());
        perr(-222);
        cmd(CMD_CLS);
        rd(CMD_EVF_RD, 0, "evf", 0);
        rd(CMD_ERR_CNT, 0, "cnt", 0);
        $display("reset and clear test done");
        finish_test();
    end
endmodule
